// ==== design/canrx_pkg.sv ====
// constants, register map and helper functions of the can receive block
package canrx_pkg;

  // ==========================================================================
  // sizes
  localparam int QUEUE_BYTES = 64;
  localparam int PTR_W       = 6;
  localparam int WIN_BYTES   = 13;

  localparam logic [3:0] STD_DESC_LEN   = 4'h3;
  localparam logic [3:0] EXT_DESC_LEN   = 4'h5;
  localparam logic [3:0] MAX_DATA_BYTES = 4'h8;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE              = 8'h00;
  localparam logic [7:0] IDX_CMD               = 8'h01;
  localparam logic [7:0] IDX_STATUS            = 8'h02;
  localparam logic [7:0] IDX_INT               = 8'h03;
  localparam logic [7:0] IDX_INT_EN            = 8'h04;
  localparam logic [7:0] IDX_RX_FRAME_INFO     = 8'h10;
  localparam logic [7:0] IDX_RX_IDENTIFIER_1   = 8'h11;
  localparam logic [7:0] IDX_RX_IDENTIFIER_2   = 8'h12;
  localparam logic [7:0] IDX_RX_IDENTIFIER_3   = 8'h13;
  localparam logic [7:0] IDX_RX_IDENTIFIER_4   = 8'h14;
  localparam logic [7:0] IDX_WIN_LAST          = 8'h1c;
  localparam logic [7:0] IDX_MSG_COUNT         = 8'h1d;
  localparam logic [7:0] IDX_CODE0             = 8'h20;
  localparam logic [7:0] IDX_MASK0             = 8'h24;

  // ==========================================================================
  // field positions
  localparam int MODE_FILTER_BIT = 3;
  localparam int CMD_RELEASE_BIT = 2;
  localparam int CMD_CLR_OVR_BIT = 3;
  localparam int ST_RX_AVAIL_BIT = 0;
  localparam int ST_OVERRUN_BIT  = 1;
  localparam int ST_BUSY_BIT     = 4;
  localparam int INT_OVERRUN_BIT = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;

  // ==========================================================================
  // data bytes actually carried: none for remote frames, never above eight
  function automatic logic [3:0] data_count(input logic       rtr,
                                            input logic [3:0] dlc);
    if (rtr) begin
      return 4'h0;
    end
    return (dlc > MAX_DATA_BYTES) ? MAX_DATA_BYTES : dlc;
  endfunction

  // bytes one message occupies in the queue, from its frame info byte
  function automatic logic [3:0] msg_len(input logic [7:0] info);
    logic [3:0] desc;
    desc = info[7] ? EXT_DESC_LEN : STD_DESC_LEN;
    return desc + data_count(info[6], info[3:0]);
  endfunction

endpackage

// ==== design/canrx_filter.sv ====
// acceptance filter: single and dual filter modes, standard and extended
`timescale 1ns/1ns
`default_nettype none
module canrx_filter (
  input  wire logic        single_mode,
  input  wire logic        ext,
  input  wire logic        rtr,
  input  wire logic [3:0]  dlc,
  input  wire logic [28:0] id,
  input  wire logic [7:0]  data1,
  input  wire logic [7:0]  data2,
  input  wire logic [31:0] code,
  input  wire logic [31:0] mask,
  output logic             accept
);

  logic [3:0] nbytes;
  logic       s_std;
  logic       s_ext;
  logic       d_std1;
  logic       d_std2;
  logic       d_ext1;
  logic       d_ext2;
  logic [7:0] d1_dc;
  logic [7:0] d2_dc;

  // ==========================================================================
  // mask bit high means don't care; code byte 0 sits in bits 31:24
  assign nbytes = canrx_pkg::data_count(rtr, dlc);
  // missing data bytes never block a frame
  assign d1_dc  = (nbytes < 4'h1) ? 8'hff : 8'h00;
  assign d2_dc  = (nbytes < 4'h2) ? 8'hff : 8'h00;

  assign s_std = &(~({id[28:18], rtr, 4'h0, data1, data2} ^ code)
                   | mask | {16'h0000, d1_dc, d2_dc});
  assign s_ext = &(~({id, rtr, 2'b00} ^ code) | mask);

  // filter 1: id, rtr, data byte 1 split over the low nibbles of bytes 1, 3
  assign d_std1 = &(~({id[28:18], rtr, data1}
                      ^ {code[31:20], code[19:16], code[3:0]})
                    | {mask[31:20], mask[19:16] | d1_dc[3:0],
                       mask[3:0] | d1_dc[7:4]});
  assign d_std2 = &(~({id[28:18], rtr} ^ {code[15:8], code[7:4]})
                    | {mask[15:8], mask[7:4]});
  assign d_ext1 = &(~(id[28:13] ^ code[31:16]) | mask[31:16]);
  assign d_ext2 = &(~(id[28:13] ^ code[15:0]) | mask[15:0]);

  assign accept = single_mode ? (ext ? s_ext : s_std)
                              : (ext ? (d_ext1 | d_ext2) : (d_std1 | d_std2));

endmodule
`default_nettype wire

// ==== design/canrx_desc.sv ====
// packs a received frame into the byte layout of the receive buffer
`timescale 1ns/1ns
`default_nettype none
module canrx_desc (
  input  wire logic        ext,
  input  wire logic        rtr,
  input  wire logic [3:0]  dlc,
  input  wire logic [28:0] id,
  input  wire logic [63:0] data,
  output logic [103:0]     msg_bytes,
  output logic [3:0]       len
);

  logic [7:0] b [canrx_pkg::WIN_BYTES];
  logic [3:0] nbytes;
  logic [3:0] base;

  assign nbytes = canrx_pkg::data_count(rtr, dlc);
  assign base   = ext ? canrx_pkg::EXT_DESC_LEN : canrx_pkg::STD_DESC_LEN;
  assign len    = base + nbytes;

  always_comb begin
    for (int k = 0; k < canrx_pkg::WIN_BYTES; k++) begin
      b[k] = 8'h00;
    end
    b[0] = {ext, rtr, 2'b00, dlc};
    b[1] = id[28:21];
    if (ext) begin
      b[2] = id[20:13];
      b[3] = id[12:5];
      b[4] = {id[4:0], rtr, 2'b00};
    end else begin
      b[2] = {id[20:18], rtr, 4'h0};
    end
    // data byte 1 at index 3 (standard) or 5 (extended)
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < nbytes) begin
        b[4'(k) + base] = data[63 - 8 * k -: 8];
      end
    end
    for (int k = 0; k < canrx_pkg::WIN_BYTES; k++) begin
      msg_bytes[8 * k +: 8] = b[k];
    end
  end

endmodule
`default_nettype wire

// ==== design/canrx_top.sv ====
// receive buffer, message queue and acceptance filter behind ahb-lite
`timescale 1ns/1ns
`default_nettype none
module canrx_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rx_start,
  input  wire logic        rx_ext,
  input  wire logic        rx_rtr,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [28:0] rx_id,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  input  wire logic        rx_done,
  input  wire logic [28:0] tx_id,
  output logic             own_wins,
  output logic             overrun_irq
);

  localparam int PW = canrx_pkg::PTR_W;

  typedef enum logic [0:0] {
    CANRX_IDLE  = 1'b0,
    CANRX_WRITE = 1'b1
  } canrx_state_t;

  // ==========================================================================
  // storage and state
  logic [7:0]   ram [canrx_pkg::QUEUE_BYTES];
  canrx_state_t state_ff;
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0]   used_ff;
  logic [4:0]    count_ff;
  logic [3:0]    idx_ff;
  logic [3:0]    len_ff;
  logic [103:0]  stage_ff;
  logic          rx_ext_ff;
  logic          rx_rtr_ff;
  logic [3:0]    rx_dlc_ff;
  logic [28:0]   rx_id_ff;
  logic [63:0]   rx_data_ff;
  logic [6:0]    bitcnt_ff;
  logic [7:0]    mode_ff;
  logic [7:0]    int_en_ff;
  logic [31:0]   code_ff;
  logic [31:0]   mask_ff;
  logic          ovr_st_ff;
  logic          ovr_int_ff;
  logic          own_wins_ff;
  logic [31:0]   hrdata_ff;
  logic          wr_pend_ff;
  logic [7:0]    wr_idx_ff;

  logic [103:0]  msg_bytes;
  logic [3:0]    msg_len;
  logic          accept;
  logic [PW:0]   free_bytes;
  logic          take;
  logic          take_rd;
  logic [7:0]    a_idx;
  logic          cmd_wr;
  logic          release_go;
  logic [3:0]    rel_len;
  logic          commit;
  logic          ovr_event;
  logic          done_go;
  logic [7:0]    rd_val;
  logic [PW-1:0] win_addr;

  // ==========================================================================
  // frame packing and acceptance
  canrx_desc u_desc (
    .ext       (rx_ext_ff),
    .rtr       (rx_rtr_ff),
    .dlc       (rx_dlc_ff),
    .id        (rx_id_ff),
    .data      (rx_data_ff),
    .msg_bytes (msg_bytes),
    .len       (msg_len)
  );

  canrx_filter u_filter (
    .single_mode (mode_ff[canrx_pkg::MODE_FILTER_BIT]),
    .ext         (rx_ext_ff),
    .rtr         (rx_rtr_ff),
    .dlc         (rx_dlc_ff),
    .id          (rx_id_ff),
    .data1       (rx_data_ff[63:56]),
    .data2       (rx_data_ff[55:48]),
    .code        (code_ff),
    .mask        (mask_ff),
    .accept      (accept)
  );

  // ==========================================================================
  // ahb-lite decode; zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign take      = hsel & htrans[1] & hready;
  assign take_rd   = take & ~hwrite;
  assign a_idx     = haddr[9:2];
  assign cmd_wr    = wr_pend_ff & (wr_idx_ff == canrx_pkg::IDX_CMD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end else begin
      wr_pend_ff <= take & hwrite;
      wr_idx_ff  <= a_idx;
    end
  end

  // the window reads the oldest message, wrapping at the queue end
  assign win_addr = rd_ptr_ff + PW'(a_idx - canrx_pkg::IDX_RX_FRAME_INFO);

  always_comb begin
    rd_val = 8'h00;
    if (a_idx >= canrx_pkg::IDX_RX_FRAME_INFO &&
        a_idx <= canrx_pkg::IDX_WIN_LAST) begin
      if (count_ff != 5'h00) begin
        rd_val = ram[win_addr];
      end
    end else if (a_idx >= canrx_pkg::IDX_CODE0 &&
                 a_idx < canrx_pkg::IDX_MASK0) begin
      rd_val = code_ff[8 * (3 - int'(a_idx[1:0])) +: 8];
    end else if (a_idx >= canrx_pkg::IDX_MASK0 &&
                 a_idx < canrx_pkg::IDX_MASK0 + 8'h04) begin
      rd_val = mask_ff[8 * (3 - int'(a_idx[1:0])) +: 8];
    end else begin
      case (a_idx)
        canrx_pkg::IDX_MODE:      rd_val = mode_ff;
        canrx_pkg::IDX_INT_EN:    rd_val = int_en_ff;
        canrx_pkg::IDX_MSG_COUNT: rd_val = {3'b000, count_ff};
        canrx_pkg::IDX_STATUS: begin
          rd_val[canrx_pkg::ST_RX_AVAIL_BIT] = (count_ff != 5'h00);
          rd_val[canrx_pkg::ST_OVERRUN_BIT]  = ovr_st_ff;
          rd_val[canrx_pkg::ST_BUSY_BIT]     = (state_ff == CANRX_WRITE);
        end
        canrx_pkg::IDX_INT: rd_val[canrx_pkg::INT_OVERRUN_BIT] = ovr_int_ff;
        default: rd_val = 8'h00;
      endcase
    end
  end

  // read data is captured in the address phase so it is a flop output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (take_rd) begin
      hrdata_ff <= {24'h00_0000, rd_val};
    end
  end

  // ==========================================================================
  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff   <= canrx_pkg::MODE_RESET;
      int_en_ff <= 8'h00;
      code_ff   <= {4{canrx_pkg::CODE_RESET}};
      mask_ff   <= {4{canrx_pkg::MASK_RESET}};
    end else if (wr_pend_ff) begin
      if (wr_idx_ff == canrx_pkg::IDX_MODE) begin
        mode_ff <= hwdata[7:0];
      end
      if (wr_idx_ff == canrx_pkg::IDX_INT_EN) begin
        int_en_ff <= hwdata[7:0];
      end
      if (wr_idx_ff >= canrx_pkg::IDX_CODE0 &&
          wr_idx_ff < canrx_pkg::IDX_MASK0) begin
        code_ff[8 * (3 - int'(wr_idx_ff[1:0])) +: 8] <= hwdata[7:0];
      end
      if (wr_idx_ff >= canrx_pkg::IDX_MASK0 &&
          wr_idx_ff < canrx_pkg::IDX_MASK0 + 8'h04) begin
        mask_ff[8 * (3 - int'(wr_idx_ff[1:0])) +: 8] <= hwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // frame capture from the bit stream processor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ext_ff  <= 1'b0;
      rx_rtr_ff  <= 1'b0;
      rx_dlc_ff  <= 4'h0;
      rx_id_ff   <= 29'h0000_0000;
      rx_data_ff <= 64'h0000_0000_0000_0000;
      bitcnt_ff  <= 7'h00;
    end else if (rx_start) begin
      rx_ext_ff  <= rx_ext;
      rx_rtr_ff  <= rx_rtr;
      rx_dlc_ff  <= rx_dlc;
      rx_id_ff   <= rx_id;
      rx_data_ff <= 64'h0000_0000_0000_0000;
      bitcnt_ff  <= 7'h00;
    end else if (rx_bit_valid && !bitcnt_ff[6]) begin
      rx_data_ff[~bitcnt_ff[5:0]] <= rx_bit;
      bitcnt_ff                   <= bitcnt_ff + 7'h01;
    end
  end

  // lower value has more leading dominant bits and so wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      own_wins_ff <= 1'b0;
    end else begin
      own_wins_ff <= (tx_id < rx_id_ff);
    end
  end
  assign own_wins = own_wins_ff;

  // ==========================================================================
  // queue writer; room is judged before any byte goes in, so a message
  // that does not fit is dropped whole and the write pointer never moves
  assign free_bytes = 7'(canrx_pkg::QUEUE_BYTES) - used_ff;
  assign done_go    = rx_done & (state_ff == CANRX_IDLE) & accept;
  assign ovr_event  = done_go & ({3'b000, msg_len} > free_bytes);
  assign commit     = (state_ff == CANRX_WRITE) & (idx_ff == len_ff - 4'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= CANRX_IDLE;
      idx_ff   <= 4'h0;
      len_ff   <= 4'h0;
      stage_ff <= 104'h0;
    end else begin
      case (state_ff)
        CANRX_IDLE: begin
          if (done_go && !ovr_event) begin
            state_ff <= CANRX_WRITE;
            idx_ff   <= 4'h0;
            len_ff   <= msg_len;
            stage_ff <= msg_bytes;
          end
        end
        CANRX_WRITE: begin
          idx_ff <= idx_ff + 4'h1;
          if (commit) begin
            state_ff <= CANRX_IDLE;
          end
        end
        default: state_ff <= CANRX_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk) begin
    if (state_ff == CANRX_WRITE) begin
      ram[wr_ptr_ff + PW'(idx_ff)] <= stage_ff[8 * idx_ff +: 8];
    end
  end

  // ==========================================================================
  // pointers, fill level and message count
  assign rel_len    = canrx_pkg::msg_len(ram[rd_ptr_ff]);
  assign release_go = cmd_wr & hwdata[canrx_pkg::CMD_RELEASE_BIT] &
                      (count_ff != 5'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      used_ff   <= '0;
      count_ff  <= 5'h00;
    end else begin
      if (commit) begin
        wr_ptr_ff <= wr_ptr_ff + PW'(len_ff);
      end
      if (release_go) begin
        rd_ptr_ff <= rd_ptr_ff + PW'(rel_len);
      end
      used_ff  <= used_ff + (commit ? 7'(len_ff) : 7'h00)
                          - (release_go ? 7'(rel_len) : 7'h00);
      count_ff <= count_ff + (commit ? 5'h01 : 5'h00)
                           - (release_go ? 5'h01 : 5'h00);
    end
  end

  // ==========================================================================
  // overrun status and interrupt; a new overrun beats a clear or a read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_st_ff  <= 1'b0;
      ovr_int_ff <= 1'b0;
    end else begin
      if (ovr_event) begin
        ovr_st_ff <= 1'b1;
      end else if (cmd_wr && hwdata[canrx_pkg::CMD_CLR_OVR_BIT]) begin
        ovr_st_ff <= 1'b0;
      end
      if (ovr_event && int_en_ff[canrx_pkg::INT_OVERRUN_BIT]) begin
        ovr_int_ff <= 1'b1;
      end else if (take_rd && a_idx == canrx_pkg::IDX_INT) begin
        ovr_int_ff <= 1'b0;
      end
    end
  end
  assign overrun_irq = ovr_int_ff;

  // hsize is not checked: every register answers as one whole word
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:10], haddr[1:0], hwdata[31:8]};

endmodule
`default_nettype wire

// ==== tb/canrx_node_model.sv ====
// frame sender standing in for the other nodes on the bus
`timescale 1ns/1ns
`default_nettype none
module canrx_node_model (
  input  wire logic        hclk,
  output logic             rx_start,
  output logic             rx_ext,
  output logic             rx_rtr,
  output logic [3:0]       rx_dlc,
  output logic [28:0]      rx_id,
  output logic             rx_bit_valid,
  output logic             rx_bit,
  output logic             rx_done
);
  initial begin
    {rx_start, rx_ext, rx_rtr, rx_dlc, rx_id} = '0;
    {rx_bit_valid, rx_bit, rx_done} = '0;
  end
  // ========
  // header pulse, data bits, then the done pulse
  task automatic send(input logic e, r, input logic [3:0] dlc,
                      input logic [28:0] id, input logic [63:0] d);
    int n;
    n = r ? 0 : ((dlc > 4'h8) ? 64 : 8 * dlc);
    rx_start <= 1'b1;
    {rx_ext, rx_rtr, rx_dlc, rx_id} <= {e, r, dlc, id};
    @(posedge hclk);
    rx_start <= 1'b0;
    // header no longer held once taken
    {rx_ext, rx_rtr, rx_dlc, rx_id} <= ~{e, r, dlc, id};
    for (int i = 0; i < n; i++) begin
      rx_bit_valid <= 1'b1;
      rx_bit       <= d[63 - i];
      @(posedge hclk);
    end
    rx_bit_valid <= 1'b0;
    rx_bit       <= ~rx_bit;
    rx_done      <= 1'b1;
    @(posedge hclk);
    rx_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/canrx_top_assertions.sv ====
// assertion checker for the can receive block, bound at the foot
`timescale 1ns/1ns
`default_nettype none
module canrx_top_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rx_start,
  input wire logic [28:0] rx_id,
  input wire logic        rx_done,
  input wire logic [28:0] tx_id,
  input wire logic        own_wins,
  input wire logic        overrun_irq
);
  logic [28:0] rx_id_ff;
  logic        rd_ph;
  logic        rd_int;
  assign rd_ph  = hsel && htrans[1] && hready && !hwrite;
  assign rd_int = rd_ph && haddr[9:2] == canrx_pkg::IDX_INT;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ========
  // identifier held since the last frame start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_id_ff <= '0;
    end else if (rx_start) begin
      rx_id_ff <= rx_id;
    end
  end
  // ========
  // checks
  a_zero_wait: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_upper_zero: assert property (hrdata[31:8] == '0)
    else $error("hrdata upper bits set");
  a_rdata_holds: assert property (!$past(rd_ph) |-> $stable(hrdata))
    else $error("hrdata changed without a read");
  a_unmapped_zero: assert property (
    rd_ph && haddr[9:2] == 8'hff |=> hrdata == '0)
    else $error("unmapped read not zero");
  a_own_wins_order: assert property (
    own_wins == ($past(tx_id) < $past(rx_id_ff)))
    else $error("own_wins wrong");
  a_irq_has_cause: assert property (
    $rose(overrun_irq) |-> $past(rx_done) || $past(rx_done, 2))
    else $error("overrun_irq rose without a frame");
  a_irq_read_clear: assert property (
    $fell(overrun_irq) |-> $past(rd_int) || $past(rd_int, 2))
    else $error("overrun_irq fell without a read");
  c_overrun: cover property ($rose(overrun_irq));
  c_own_wins: cover property ($rose(own_wins));
  c_window: cover property (rd_ph && haddr[9:2] == 8'h10);
endmodule
bind canrx_top canrx_top_assertions chk_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .rx_start, .rx_id, .rx_done, .tx_id, .own_wins,
  .overrun_irq
);
`default_nettype wire

// ==== tb/tb_can_rx_buffer_acceptance_filter.sv ====
// self-checking bench for the can receive block
`timescale 1ns/1ns
`default_nettype none
module tb_can_rx_buffer_acceptance_filter;
  localparam logic [28:0] SID = {11'h5a3, 18'h0};
  localparam logic [28:0] XID = 29'h1357_9bdf;
  localparam logic [63:0] DAT = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] DB2 = 64'h0124_4567_89ab_cdef;
  localparam logic [7:0]  REL = 8'(1 << canrx_pkg::CMD_RELEASE_BIT);
  localparam logic [7:0]  SGL = 8'(1 << canrx_pkg::MODE_FILTER_BIT);
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        rx_start, rx_ext, rx_rtr, rx_bit_valid, rx_bit, rx_done;
  logic        own_wins, overrun_irq;
  logic [1:0]  htrans;
  logic [3:0]  rx_dlc;
  logic [28:0] rx_id, tx_id;
  logic [31:0] haddr, hwdata, hrdata;
  int          num_errors = 0;
  int          samples_checked = 0;
  canrx_top dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_start,
    .rx_ext, .rx_rtr, .rx_dlc, .rx_id, .rx_bit_valid, .rx_bit, .rx_done,
    .tx_id, .own_wins, .overrun_irq
  );
  canrx_node_model node_u (
    .hclk, .rx_start, .rx_ext, .rx_rtr, .rx_dlc, .rx_id, .rx_bit_valid,
    .rx_bit, .rx_done
  );
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #200_000;
    num_errors++;
    give_verdict();
  end
  // ========
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    check(x, exp);
  endtask
  // the queue needs up to 13 cycles to store a message
  task automatic frame(input logic e, r, input logic [3:0] dlc,
                       input logic [28:0] id, input logic [63:0] d);
    node_u.send(e, r, dlc, id, d);
    repeat (14) @(posedge hclk);
  endtask
  // ========
  // scenarios
  task automatic t_reset();
    rd_chk(canrx_pkg::IDX_MODE, canrx_pkg::MODE_RESET);
    rd_chk(canrx_pkg::IDX_CODE0, canrx_pkg::CODE_RESET);
    rd_chk(canrx_pkg::IDX_MASK0, canrx_pkg::MASK_RESET);
    rd_chk(canrx_pkg::IDX_MSG_COUNT, 8'h00);
    wr(canrx_pkg::IDX_RX_FRAME_INFO, 8'h5a);
    rd_chk(canrx_pkg::IDX_RX_FRAME_INFO, 8'h00);
    rd_chk(8'hff, 8'h00);
  endtask
  task automatic show(input logic e, r, input logic [3:0] dlc,
                      input logic [28:0] id);
    logic [7:0] x [13];
    int         nd;
    int         hd;
    nd = r ? 0 : ((dlc > 4'h8) ? 8 : dlc);
    hd = e ? 5 : 3;
    x[0] = {e, r, 2'b00, dlc};
    x[1] = id[28:21];
    x[2] = e ? id[20:13] : {id[20:18], r, 4'h0};
    x[3] = id[12:5];
    x[4] = {id[4:0], r, 2'b00};
    for (int i = 0; i < nd; i++) x[hd + i] = DAT[63 - 8 * i -: 8];
    frame(e, r, dlc, id, DAT);
    rd_chk(canrx_pkg::IDX_MSG_COUNT, 8'h01);
    for (int i = 0; i < hd + nd; i++) begin
      rd_chk(8'h10 + 8'(i), x[i]);
    end
    wr(canrx_pkg::IDX_CMD, REL);
  endtask
  task automatic t_layout();
    show(0, 0, 4'h9, SID);
    show(0, 1, 4'h5, SID);
    show(1, 1, 4'h3, XID);
    show(1, 0, 4'h1, XID);
  endtask
  task automatic acc(input logic m, input logic [31:0] c, k, input logic e,
                     r, input logic [3:0] dlc, input logic [28:0] id,
                     input logic [63:0] d, input logic ok);
    wr(canrx_pkg::IDX_MODE, m ? SGL : 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(canrx_pkg::IDX_CODE0 + 8'(i), c[31 - 8 * i -: 8]);
      wr(canrx_pkg::IDX_MASK0 + 8'(i), k[31 - 8 * i -: 8]);
    end
    frame(e, r, dlc, id, d);
    rd_chk(canrx_pkg::IDX_MSG_COUNT, {7'h0, ok});
    if (ok) begin
      wr(canrx_pkg::IDX_CMD, REL);
    end
  endtask
  task automatic t_filter();
    acc(1, 32'hb460_0123, 32'h000f_0000, 0, 0, 2, SID, DAT, 1);
    acc(1, 32'hb460_0123, 32'h000f_0000, 0, 0, 2, SID, DB2, 0);
    acc(1, 32'hb460_0123, 32'h000f_0000, 0, 0, 1, SID, DB2, 1);
    acc(1, 32'h9abc_def8, 32'h0000_0003, 1, 0, 2, XID, DAT, 1);
    acc(1, 32'h9abc_def8, 32'h0000_0003, 1, 0, 2, XID ^ 1, DAT, 0);
    acc(0, 32'h0060_b461, 32'h0, 0, 0, 2, SID, DAT, 1);
    acc(0, 32'h0060_0061, 32'h0, 0, 0, 2, SID, DAT, 0);
    acc(0, 32'hb46f_0001, 32'h0, 0, 0, 2, SID, DAT, 0);
    acc(0, 32'hb47f_0001, 32'h0, 0, 1, 2, SID, DAT, 1);
    acc(0, 32'hb46f_0001, 32'h0, 0, 0, 0, SID, DAT, 1);
    acc(0, 32'hb46f_000f, 32'h000f_000f, 0, 0, 2, SID, DAT, 1);
    acc(0, 32'h9abc_0000, 32'h0, 1, 0, 2, 29'h1357_9bff, DAT, 1);
    acc(0, 32'h9abc_0000, 32'h0, 1, 0, 2, 29'h1357_bbdf, DAT, 0);
    acc(0, 32'h0, 32'hffff_ffff, 0, 0, 0, SID, DAT, 1);
  endtask
  task automatic t_overrun();
    wr(canrx_pkg::IDX_INT_EN, 8'h08);
    repeat (6) frame(0, 0, 4'h8, SID, DAT);
    rd_chk(canrx_pkg::IDX_MSG_COUNT, 8'h05);
    rd_chk(canrx_pkg::IDX_STATUS, 8'h03);
    check(overrun_irq, 1);
    rd_chk(canrx_pkg::IDX_INT, 8'h08);
    check(overrun_irq, 0);
    wr(canrx_pkg::IDX_INT_EN, 8'h00);
    wr(canrx_pkg::IDX_CMD, 8'h08);
    frame(0, 0, 4'h1, SID, DAT);
    frame(0, 0, 4'h2, SID, DAT);
    rd_chk(canrx_pkg::IDX_MSG_COUNT, 8'h07);
    rd_chk(canrx_pkg::IDX_STATUS, 8'h01);
    frame(0, 1, 4'h0, SID, DAT);
    rd_chk(canrx_pkg::IDX_STATUS, 8'h03);
    check(overrun_irq, 0);
    wr(canrx_pkg::IDX_CMD, 8'h08);
    repeat (8) wr(canrx_pkg::IDX_CMD, REL);
    rd_chk(canrx_pkg::IDX_MSG_COUNT, 8'h00);
    rd_chk(canrx_pkg::IDX_STATUS, 8'h00);
  endtask
  task automatic t_arb();
    tx_id <= SID - 29'h1;
    repeat (2) @(posedge hclk);
    check(own_wins, 1);
    tx_id <= SID;
    repeat (2) @(posedge hclk);
    check(own_wins, 0);
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = '0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hwdata  = '0;
    tx_id   = '1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_layout();
    t_filter();
    t_overrun();
    t_arb();
    give_verdict();
  end
endmodule
`default_nettype wire
